// ===== shared/lpi2c_defines.vh
// register map, field positions, reset values and timing constants of the byte master
`ifndef LPI2C_DEFINES_VH
`define LPI2C_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define LPI2C_SLOT_PAIR_01 32'h3FF4883C
`define LPI2C_SLOT_PAIR_23 32'h3FF48840
`define LPI2C_SLOT_PAIR_45 32'h3FF48844
`define LPI2C_SLOT_PAIR_67 32'h3FF48848
`define LPI2C_XFER_CTRL 32'h3FF48850
`define LPI2C_SCL_LOW 32'h3FF48C00
`define LPI2C_CTRL 32'h3FF48C04
`define LPI2C_DEBUG 32'h3FF48C08
`define LPI2C_TIMEOUT 32'h3FF48C0C
`define LPI2C_EV_CLEAR 32'h3FF48C24
`define LPI2C_EV_ENABLE 32'h3FF48C28
`define LPI2C_EV_STATUS 32'h3FF48C2C
`define LPI2C_SDA_DUTY 32'h3FF48C30
`define LPI2C_SCL_HIGH 32'h3FF48C38
`define LPI2C_START_WAIT 32'h3FF48C40
`define LPI2C_STOP_WAIT 32'h3FF48C44
`define LPI2C_PIN_ROUTE 32'h3FF48C80

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LPI2C_SLOT_W 11
`define LPI2C_PAIR_RDATA_LSB 22
`define LPI2C_PAIR_DONE_BIT 30
`define LPI2C_XC_START_BIT 28
`define LPI2C_XC_FORCE_BIT 29
`define LPI2C_CTRL_SCL_PP_BIT 0
`define LPI2C_CTRL_SDA_PP_BIT 1
`define LPI2C_CTRL_MASTER_BIT 4
`define LPI2C_INS_SEL_LSB 22
`define LPI2C_INS_DIR_BIT 27
`define LPI2C_EV_TIMEOUT 0
`define LPI2C_EV_STOP 1
`define LPI2C_EV_MASTER_DONE 2
`define LPI2C_EV_ARB_LOST 3
`define LPI2C_EV_NACK 4
`define LPI2C_EV_W 5

// ----------------------------------------------------------------------------
// reset values (fast-clock cycles)
// ----------------------------------------------------------------------------
`define LPI2C_RST_SCL_LOW 40
`define LPI2C_RST_SCL_HIGH 40
`define LPI2C_RST_SDA_DUTY 16
`define LPI2C_RST_START_WAIT 30
`define LPI2C_RST_STOP_WAIT 44
`define LPI2C_RST_TIMEOUT 200

`endif

// ===== core/lpi2c_master.v
// single-byte register read/write i2c master with register file and pin routing
`timescale 1ns/100ps
`default_nettype none
`include "lpi2c_defines.vh"

// Overview of operation
// - read: START, address with direction 0, register address, repeated START, address dir 1.
// - read ends taking one byte, answering NACK, then STOP.
// - write: after repeated START, address dir 0, one data byte, STOP after ack.
// - slave address comes from one of eight slots chosen by instruction argument.
// - byte read from slave on an instruction is written into general register zero; a software-started read is not.
// - SDA is sampled on each falling edge of SCL.
// - SCL low and high half-periods are separately programmable in fast-clock cycles.
// - SDA changes a programmable number of cycles after SCL falls.
// - after START the master waits a programmable number of cycles.
// - before STOP the master waits a programmable number of cycles.
// - a transaction longer than the programmed timeout raises a timeout event.
// - read and write share one opcode, told apart by a direction operand.
// - errors appear only in event status bits, never in co-processor registers.
// - an event latches only when its enable bit, shifted up by one, is set.
// - a latched event bit clears by writing its bit in the clear register.
// - SDA and SCL route to two of four candidate pins by a routing register.
// - direction operand 1 selects write, 0 selects read.
module lpi2c_master #(
  parameter CW = 20
) (
  input wire core_clk,
  input wire reset_n,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire instr_valid,
  input wire [31:0] instr_word,
  output reg instr_done,
  output reg gr0_we,
  output reg [15:0] gr0_wdata,
  input wire [3:0] pad_in,
  output wire [3:0] pad_out,
  output wire [3:0] pad_oe
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_LOW = 3'h2;
  localparam [2:0] S_HIGH = 3'h3;
  localparam [2:0] S_RS_LOW = 3'h4;
  localparam [2:0] S_RS_HIGH = 3'h5;
  localparam [2:0] S_STOP_LOW = 3'h6;
  localparam [2:0] S_STOP_HIGH = 3'h7;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  reg [21:0] pair01_q, pair23_q, pair45_q, pair67_q;
  reg [29:0] xfer_ctrl_q;
  reg [4:0] ctrl_q;
  reg [CW-1:0] scl_low_q, scl_high_q, sda_duty_q, start_wait_q, stop_wait_q, timeout_q;
  reg [`LPI2C_EV_W:0] ev_en_q;
  reg [`LPI2C_EV_W-1:0] ev_st_q;
  reg [`LPI2C_EV_W-1:0] ev_q;
  reg [1:0] route_q;
  reg [7:0] rdata_q;
  reg done_flag_q;
  reg sw_start_prev_q;
  reg [3:0] pad_meta_q, pad_sync_q;
  reg [2:0] state_q;
  reg [CW-1:0] cnt_q, tout_cnt_q;
  reg [3:0] bit_q;
  reg [1:0] byte_q;
  reg [8:0] shift_q;
  reg [7:0] rx_q;
  reg scl_q, sda_q;
  reg cmd_write_q, from_ulp_q;
  reg [7:0] cmd_sub_q, cmd_data_q;
  reg [6:0] slave_addr_q;
  wire sw_go;
  wire ulp_go;
  wire go;
  wire [31:0] cmd;
  wire [2:0] cmd_sel;
  wire sda_in;
  wire master_mode;
  wire [21:0] sel_pair;
  wire [6:0] sel_addr;

  // --------------------------------------------------------------------------
  // pad input synchroniser
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      pad_meta_q <= 4'h0;
      pad_sync_q <= 4'h0;
    end else begin
      pad_meta_q <= pad_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  assign sda_in = route_q[1] ? pad_sync_q[3] : pad_sync_q[2];
  assign master_mode = ctrl_q[`LPI2C_CTRL_MASTER_BIT];

  // --------------------------------------------------------------------------
  // command source and slot selection
  // --------------------------------------------------------------------------
  assign sw_go = xfer_ctrl_q[`LPI2C_XC_FORCE_BIT] & xfer_ctrl_q[`LPI2C_XC_START_BIT] &
                 ~sw_start_prev_q & (state_q == S_IDLE);
  assign ulp_go = instr_valid & (state_q == S_IDLE) & ~sw_go;
  assign go = sw_go | ulp_go;
  assign cmd = sw_go ? {4'h0, xfer_ctrl_q[27:0]} : instr_word;
  assign cmd_sel = cmd[`LPI2C_INS_SEL_LSB+2:`LPI2C_INS_SEL_LSB];
  assign sel_pair = (cmd_sel[2:1] == 2'h0) ? pair01_q :
                    (cmd_sel[2:1] == 2'h1) ? pair23_q :
                    (cmd_sel[2:1] == 2'h2) ? pair45_q : pair67_q;
  assign sel_addr = cmd_sel[0] ? sel_pair[`LPI2C_SLOT_W+6:`LPI2C_SLOT_W] : sel_pair[6:0];

  function [8:0] tx_bits;
    input [1:0] idx;
    input [6:0] addr;
    input wr;
    input [7:0] sub;
    input [7:0] data;
    begin
      case (idx)
        2'h0: tx_bits = {addr, 1'b0, 1'b1};
        2'h1: tx_bits = {sub, 1'b1};
        2'h2: tx_bits = {addr, ~wr, 1'b1};
        default: tx_bits = wr ? {data, 1'b1} : 9'h1FF;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // bus engine
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      cnt_q <= {CW{1'b0}};
      tout_cnt_q <= {CW{1'b0}};
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      shift_q <= 9'h1FF;
      rx_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cmd_write_q <= 1'b0;
      from_ulp_q <= 1'b0;
      cmd_sub_q <= 8'h00;
      cmd_data_q <= 8'h00;
      slave_addr_q <= 7'h00;
      ev_q <= {`LPI2C_EV_W{1'b0}};
      instr_done <= 1'b0;
      gr0_we <= 1'b0;
      gr0_wdata <= 16'h0000;
      rdata_q <= 8'h00;
      done_flag_q <= 1'b0;
    end else begin
      ev_q <= {`LPI2C_EV_W{1'b0}};
      instr_done <= 1'b0;
      gr0_we <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      tout_cnt_q <= (state_q == S_IDLE) ? {CW{1'b0}} : tout_cnt_q + 1'b1;
      if (state_q != S_IDLE && tout_cnt_q >= timeout_q) begin
        state_q <= S_IDLE;
        scl_q <= 1'b1;
        sda_q <= 1'b1;
        ev_q[`LPI2C_EV_TIMEOUT] <= 1'b1;
        instr_done <= from_ulp_q;
        done_flag_q <= 1'b1;
      end else begin
        case (state_q)
          S_IDLE: begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            if (go) begin
              done_flag_q <= 1'b0;
              from_ulp_q <= ulp_go;
              cmd_write_q <= cmd[`LPI2C_INS_DIR_BIT];
              cmd_sub_q <= cmd[7:0];
              cmd_data_q <= cmd[15:8];
              slave_addr_q <= sel_addr;
              byte_q <= 2'h0;
              cnt_q <= {CW{1'b0}};
              if (master_mode) begin
                state_q <= S_START;
                sda_q <= 1'b0;
              end else begin
                instr_done <= ulp_go;
                done_flag_q <= 1'b1;
              end
            end
          end
          S_START: begin
            if (cnt_q >= start_wait_q) begin
              state_q <= S_LOW;
              scl_q <= 1'b0;
              cnt_q <= {CW{1'b0}};
              bit_q <= 4'h0;
              shift_q <= tx_bits(byte_q, slave_addr_q, cmd_write_q, cmd_sub_q, cmd_data_q);
            end
          end
          S_LOW: begin
            if (cnt_q == sda_duty_q) begin
              sda_q <= shift_q[8];
            end
            if (cnt_q >= scl_low_q) begin
              state_q <= S_HIGH;
              scl_q <= 1'b1;
              cnt_q <= {CW{1'b0}};
            end
          end
          S_HIGH: begin
            if (cnt_q >= scl_high_q) begin
              scl_q <= 1'b0;
              cnt_q <= {CW{1'b0}};
              shift_q <= {shift_q[7:0], 1'b1};
              if (bit_q != 4'h8) begin
                rx_q <= {rx_q[6:0], sda_in};
                bit_q <= bit_q + 1'b1;
                state_q <= S_LOW;
              end else if (sda_in && (byte_q != 2'h3 || cmd_write_q)) begin
                ev_q[`LPI2C_EV_NACK] <= 1'b1;
                state_q <= S_STOP_LOW;
              end else if (byte_q == 2'h1) begin
                state_q <= S_RS_LOW;
                byte_q <= 2'h2;
              end else if (byte_q == 2'h3) begin
                state_q <= S_STOP_LOW;
              end else begin
                state_q <= S_LOW;
                bit_q <= 4'h0;
                byte_q <= byte_q + 1'b1;
                shift_q <= tx_bits(byte_q + 2'h1, slave_addr_q, cmd_write_q, cmd_sub_q,
                                   cmd_data_q);
              end
            end
          end
          S_RS_LOW: begin
            if (cnt_q == sda_duty_q) begin
              sda_q <= 1'b1;
            end
            if (cnt_q >= scl_low_q) begin
              state_q <= S_RS_HIGH;
              scl_q <= 1'b1;
              sda_q <= 1'b1;
              cnt_q <= {CW{1'b0}};
            end
          end
          S_RS_HIGH: begin
            if (cnt_q >= scl_high_q) begin
              state_q <= S_START;
              sda_q <= 1'b0;
              cnt_q <= {CW{1'b0}};
            end
          end
          S_STOP_LOW: begin
            if (cnt_q == sda_duty_q) begin
              sda_q <= 1'b0;
            end
            if (cnt_q >= scl_low_q) begin
              state_q <= S_STOP_HIGH;
              scl_q <= 1'b1;
              sda_q <= 1'b0;
              cnt_q <= {CW{1'b0}};
            end
          end
          default: begin
            if (cnt_q >= stop_wait_q) begin
              state_q <= S_IDLE;
              sda_q <= 1'b1;
              ev_q[`LPI2C_EV_STOP] <= 1'b1;
              ev_q[`LPI2C_EV_MASTER_DONE] <= 1'b1;
              instr_done <= from_ulp_q;
              done_flag_q <= 1'b1;
              if (!cmd_write_q) begin
                rdata_q <= rx_q;
                gr0_we <= from_ulp_q;
                gr0_wdata <= from_ulp_q ? {8'h00, rx_q} : gr0_wdata;
              end
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // register writes and event latching
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      pair01_q <= 22'h000000;
      pair23_q <= 22'h000000;
      pair45_q <= 22'h000000;
      pair67_q <= 22'h000000;
      xfer_ctrl_q <= 30'h00000000;
      ctrl_q <= 5'h00;
      scl_low_q <= `LPI2C_RST_SCL_LOW;
      scl_high_q <= `LPI2C_RST_SCL_HIGH;
      sda_duty_q <= `LPI2C_RST_SDA_DUTY;
      start_wait_q <= `LPI2C_RST_START_WAIT;
      stop_wait_q <= `LPI2C_RST_STOP_WAIT;
      timeout_q <= `LPI2C_RST_TIMEOUT;
      ev_en_q <= {(`LPI2C_EV_W+1){1'b0}};
      ev_st_q <= {`LPI2C_EV_W{1'b0}};
      route_q <= 2'h0;
      sw_start_prev_q <= 1'b0;
    end else begin
      sw_start_prev_q <= xfer_ctrl_q[`LPI2C_XC_START_BIT];
      if (reg_wr && reg_addr == `LPI2C_EV_CLEAR) begin
        ev_st_q <= (ev_st_q & ~reg_wdata[`LPI2C_EV_W-1:0]) |
                   (ev_q & ev_en_q[`LPI2C_EV_W:1]);
      end else begin
        ev_st_q <= ev_st_q | (ev_q & ev_en_q[`LPI2C_EV_W:1]);
      end
      if (reg_wr) begin
        if (reg_addr == `LPI2C_SLOT_PAIR_01) begin
          pair01_q <= reg_wdata[21:0];
        end else if (reg_addr == `LPI2C_SLOT_PAIR_23) begin
          pair23_q <= reg_wdata[21:0];
        end else if (reg_addr == `LPI2C_SLOT_PAIR_45) begin
          pair45_q <= reg_wdata[21:0];
        end else if (reg_addr == `LPI2C_SLOT_PAIR_67) begin
          pair67_q <= reg_wdata[21:0];
        end else if (reg_addr == `LPI2C_XFER_CTRL) begin
          xfer_ctrl_q <= reg_wdata[29:0];
        end else if (reg_addr == `LPI2C_CTRL) begin
          ctrl_q <= reg_wdata[4:0];
        end else if (reg_addr == `LPI2C_SCL_LOW) begin
          scl_low_q <= reg_wdata[CW-1:0];
        end else if (reg_addr == `LPI2C_SCL_HIGH) begin
          scl_high_q <= reg_wdata[CW-1:0];
        end else if (reg_addr == `LPI2C_SDA_DUTY) begin
          sda_duty_q <= reg_wdata[CW-1:0];
        end else if (reg_addr == `LPI2C_START_WAIT) begin
          start_wait_q <= reg_wdata[CW-1:0];
        end else if (reg_addr == `LPI2C_STOP_WAIT) begin
          stop_wait_q <= reg_wdata[CW-1:0];
        end else if (reg_addr == `LPI2C_TIMEOUT) begin
          timeout_q <= reg_wdata[CW-1:0];
        end else if (reg_addr == `LPI2C_EV_ENABLE) begin
          ev_en_q <= reg_wdata[`LPI2C_EV_W:0];
        end else if (reg_addr == `LPI2C_PIN_ROUTE) begin
          route_q <= reg_wdata[1:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // register reads, one cycle after the strobe
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == `LPI2C_SLOT_PAIR_01) begin
      reg_rdata <= {10'h000, pair01_q};
    end else if (reg_addr == `LPI2C_SLOT_PAIR_23) begin
      reg_rdata <= {10'h000, pair23_q};
    end else if (reg_addr == `LPI2C_SLOT_PAIR_45) begin
      reg_rdata <= {10'h000, pair45_q};
    end else if (reg_addr == `LPI2C_SLOT_PAIR_67) begin
      reg_rdata <= {1'b0, done_flag_q, rdata_q, pair67_q};
    end else if (reg_addr == `LPI2C_XFER_CTRL) begin
      reg_rdata <= {2'h0, xfer_ctrl_q};
    end else if (reg_addr == `LPI2C_CTRL) begin
      reg_rdata <= {27'h0000000, ctrl_q};
    end else if (reg_addr == `LPI2C_DEBUG) begin
      reg_rdata <= {27'h0000000, scl_q, sda_q, state_q};
    end else if (reg_addr == `LPI2C_SCL_LOW) begin
      reg_rdata <= {{(32-CW){1'b0}}, scl_low_q};
    end else if (reg_addr == `LPI2C_SCL_HIGH) begin
      reg_rdata <= {{(32-CW){1'b0}}, scl_high_q};
    end else if (reg_addr == `LPI2C_SDA_DUTY) begin
      reg_rdata <= {{(32-CW){1'b0}}, sda_duty_q};
    end else if (reg_addr == `LPI2C_START_WAIT) begin
      reg_rdata <= {{(32-CW){1'b0}}, start_wait_q};
    end else if (reg_addr == `LPI2C_STOP_WAIT) begin
      reg_rdata <= {{(32-CW){1'b0}}, stop_wait_q};
    end else if (reg_addr == `LPI2C_TIMEOUT) begin
      reg_rdata <= {{(32-CW){1'b0}}, timeout_q};
    end else if (reg_addr == `LPI2C_EV_ENABLE) begin
      reg_rdata <= {{(31-`LPI2C_EV_W){1'b0}}, ev_en_q};
    end else if (reg_addr == `LPI2C_EV_STATUS) begin
      reg_rdata <= {{(32-`LPI2C_EV_W){1'b0}}, ev_st_q};
    end else if (reg_addr == `LPI2C_PIN_ROUTE) begin
      reg_rdata <= {30'h00000000, route_q};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------------
  // pin routing: scl on pad 0 or 1, sda on pad 2 or 3
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pad
      localparam [1:0] PAD_IDX = gi;
      wire is_scl = (PAD_IDX == {1'b0, route_q[0]});
      wire is_sda = (PAD_IDX == {1'b1, route_q[1]});
      wire level = is_scl ? scl_q : sda_q;
      wire push_pull = is_scl ? ctrl_q[`LPI2C_CTRL_SCL_PP_BIT] : ctrl_q[`LPI2C_CTRL_SDA_PP_BIT];
      assign pad_out[gi] = (is_scl | is_sda) & push_pull & level;
      assign pad_oe[gi] = (is_scl | is_sda) & master_mode & (push_pull | ~level);
    end
  endgenerate

endmodule
`default_nettype wire

// ===== verification/lpi2c_slave_model.sv
// behavioural i2c slave with a byte memory, seen from the byte master
`timescale 1ns/100ps
`default_nettype none
module lpi2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [6:0] dev_addr,
  output logic sda_pull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] sub;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic have_sub = 1'b0;
  int bitn = 0;
  int byten = 0;
  initial sda_pull = 1'b0;
  // start or repeated start restarts byte framing
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = 0;
    byten = 0;
  end
  // stop ends the transaction
  always @(posedge sda) if (scl === 1'b1) begin
    sel = 1'b0;
    have_sub = 1'b0;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    bitn++;
  end
  always @(negedge scl) begin
    #60;
    if (bitn == 9) begin
      bitn = 0;
      byten++;
    end
    if (bitn == 8 && byten == 0) begin
      sel = (sh[7:1] == dev_addr);
      rd = sh[0];
    end else if (bitn == 8 && sel && !rd && !have_sub) begin
      sub = sh;
      have_sub = 1'b1;
    end else if (bitn == 8 && sel && !rd) begin
      mem[sub] = sh;
    end
    // released line goes back to the pull-up level
    if (bitn == 8) sda_pull = sel && !(rd && byten > 0);
    else sda_pull = sel && rd && byten == 1 && !mem[sub][7 - bitn];
  end
endmodule
`default_nettype wire

// ===== verification/lpi2c_master_props.sv
// concurrent checks on the ports of the byte master
`timescale 1ns/100ps
`default_nettype none
`include "lpi2c_defines.vh"
module lpi2c_master_props #(
  parameter int CW = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic instr_done,
  input wire logic gr0_we,
  input wire logic [15:0] gr0_wdata,
  input wire logic [3:0] pad_in,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe
);
  logic [CW-1:0] low_q;
  logic [CW:0] cnt_q;
  logic mode_q;
  logic busy_q;
  wire logic [3:0] pull_low = pad_oe & ~pad_out;
  wire logic scl_low = pull_low[0] | pull_low[1];
  wire logic sda_low = pull_low[2] | pull_low[3];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // mirror of programmed low period, master select and busy span
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      low_q <= CW'(`LPI2C_RST_SCL_LOW);
      mode_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      if (reg_wr && reg_addr == `LPI2C_SCL_LOW) low_q <= reg_wdata[CW-1:0];
      if (reg_wr && reg_addr == `LPI2C_CTRL) mode_q <= reg_wdata[`LPI2C_CTRL_MASTER_BIT];
      busy_q <= instr_done ? 1'b0 : (instr_valid | busy_q);
      cnt_q <= scl_low ? cnt_q + 1'b1 : '0;
    end
  end
  sequence s_status_read;
    reg_rd && reg_addr == `LPI2C_EV_STATUS;
  endsequence
  sequence s_start_cond;
    sda_low && !scl_low;
  endsequence
  a_start_first: assert property (
    instr_valid && !busy_q && mode_q |-> ##[1:3] s_start_cond)
    else $error("no start condition after an accepted instruction");
  a_scl_low_len: assert property (scl_low |-> cnt_q <= {1'b0, low_q})
    else $error("scl held low longer than the programmed period");
  a_status_upper: assert property (s_status_read |=> reg_rdata[31:5] == '0)
    else $error("event status shows bits beyond the event set");
  a_we_done: assert property (gr0_we |-> instr_done)
    else $error("register zero written without a done pulse");
  a_gr0_change: assert property ($past(reset_n) && $changed(gr0_wdata) |-> gr0_we)
    else $error("register zero data moved without a write");
  a_gr0_upper: assert property (gr0_wdata[15:8] == 8'h00)
    else $error("register zero upper byte not zero");
  a_done_pulse: assert property (instr_done |=> !instr_done && !busy_q)
    else $error("done pulse longer than one cycle");
  a_idle_release: assert property (instr_done |=> pull_low == 4'h0)
    else $error("bus still pulled low after the transaction ended");
  a_mode_off: assert property (!mode_q |-> pad_oe == 4'h0)
    else $error("pads driven without master select");
  a_route_one: assert property (!(pad_oe[0] && pad_oe[1]) && !(pad_oe[2] && pad_oe[3]))
    else $error("both candidate pads of one line enabled");
endmodule
bind lpi2c_master lpi2c_master_props #(.CW(CW)) i_lpi2c_master_props (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_done(instr_done), .gr0_we(gr0_we),
  .gr0_wdata(gr0_wdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
);
`default_nettype wire

// ===== verification/lpi2c_master_tb_top.sv
// self-checking bench of the byte master with a slave model on the wire
`timescale 1ns/100ps
`default_nettype none
`include "lpi2c_defines.vh"
`define CHK(nm, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); \
  end \
end
module lpi2c_master_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, instr_word = 32'h0, reg_rdata, rv;
  logic reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0, instr_done, gr0_we, we, sda_pull;
  logic [15:0] gr0_wdata;
  logic [15:0] seed = 16'h3465;
  logic [3:0] pad_out, pad_oe, pad_lvl, pad_in;
  logic [1:0] route = 2'h0;
  logic [6:0] dev_addr = 7'h00;
  logic [6:0] slot_addr [0:7];
  logic [7:0] sub, dat;
  logic [31:0] ra [0:5] = '{`LPI2C_SCL_LOW, `LPI2C_SCL_HIGH, `LPI2C_SDA_DUTY,
    `LPI2C_START_WAIT, `LPI2C_STOP_WAIT, `LPI2C_TIMEOUT};
  logic [31:0] rst_v [0:5] = '{32'h28, 32'h28, 32'h10, 32'h1E, 32'h2C, 32'hC8};
  logic [31:0] cfg_v [0:5] = '{32'h3, 32'h3, 32'h2, 32'h5, 32'h6, 32'h3E8};
  wire logic scl;
  wire logic sda;
  int fails = 0;
  int n_compared = 0;
  int n;
  always #20 core_clk = ~core_clk;
  // open-drain pads with pull-ups, slave pulls the routed data pad
  assign pad_lvl = ~pad_oe | pad_out;
  assign pad_in = pad_lvl & ~({route[1], !route[1], 2'h0} & {4{sda_pull}});
  assign scl = route[0] ? pad_in[1] : pad_in[0];
  assign sda = route[1] ? pad_in[3] : pad_in[2];
  lpi2c_master #(.CW(20)) i_lpi2c_master (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_done(instr_done), .gr0_we(gr0_we),
    .gr0_wdata(gr0_wdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
  );
  lpi2c_slave_model i_lpi2c_slave_model (
    .scl(scl), .sda(sda), .dev_addr(dev_addr), .sda_pull(sda_pull)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] pair_word(input logic [6:0] ev, input logic [6:0] od);
    return {14'h0000, od, 4'h0, ev};
  endfunction
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic run(input logic dir, input logic [2:0] slot);
    instr_word <= {4'h3, dir, 2'h0, slot, 6'h00, dat, sub};
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    we = gr0_we;
    if (n >= 3000) begin
      fails++;
      results();
    end
  endtask
  task automatic ev_check(input logic [31:0] exp, input logic [31:0] mask);
    rd(`LPI2C_EV_STATUS, rv);
    `CHK("event status", exp, rv & mask)
    wr(`LPI2C_EV_CLEAR, 32'h1F);
    wr(`LPI2C_EV_CLEAR, 32'h0);
    rd(`LPI2C_EV_STATUS, rv);
    `CHK("cleared status", 32'h0, rv)
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (int k = 0; k < 6; k++) begin
      rd(ra[k], rv);
      `CHK("reset timing", rst_v[k], rv)
      wr(ra[k], cfg_v[k]);
      rd(ra[k], rv);
      `CHK("timing readback", cfg_v[k], rv)
    end
    wr(32'h3FF48C10, 32'hFFFFFFFF);
    rd(32'h3FF48C10, rv);
    `CHK("unmapped", 32'h0, rv)
    wr(`LPI2C_EV_STATUS, 32'h1F);
    rd(`LPI2C_EV_STATUS, rv);
    `CHK("status write", 32'h0, rv)
    sub = 8'h00;
    dat = 8'h00;
    run(1'b1, 3'h0);
    `CHK("refused turnaround", 1'b1, n < 4)
    $display("test %s ended", "registers");
    wr(`LPI2C_EV_ENABLE, 32'h3E);
    wr(`LPI2C_CTRL, 32'h10);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      slot_addr[k] = seed[6:0];
    end
    for (int k = 0; k < 4; k++) begin
      wr(`LPI2C_SLOT_PAIR_01 + 32'(4 * k), pair_word(slot_addr[2 * k], slot_addr[2 * k + 1]));
    end
    rd(`LPI2C_SLOT_PAIR_01, rv);
    `CHK("slot pair", pair_word(slot_addr[0], slot_addr[1]), rv)
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      sub = seed[7:0];
      dat = seed[15:8];
      wr(`LPI2C_PIN_ROUTE, {30'h0, k[1:0]});
      route <= k[1:0];
      dev_addr = slot_addr[k];
      run(1'b1, k[2:0]);
      `CHK("slave memory", dat, i_lpi2c_slave_model.mem[sub])
      ev_check(32'h6, 32'h1F);
      run(1'b0, k[2:0]);
      `CHK("read strobe", 1'b1, we)
      `CHK("read byte", {8'h00, dat}, gr0_wdata)
      ev_check(32'h6, 32'h1F);
    end
    wr(`LPI2C_XFER_CTRL, {8'h31, 8'hC0, dat, sub});
    repeat (400) @(posedge core_clk);
    rd(`LPI2C_SLOT_PAIR_67, rv);
    `CHK("software read", {1'b1, dat}, rv[30:22])
    $display("test %s ended", "transfers");
    dev_addr = ~slot_addr[0];
    run(1'b1, 3'h0);
    `CHK("register after nack", {8'h00, dat}, gr0_wdata)
    ev_check(32'h10, 32'h10);
    dev_addr = slot_addr[0];
    wr(`LPI2C_EV_ENABLE, 32'h4);
    run(1'b1, 3'h0);
    ev_check(32'h2, 32'h1F);
    $display("test %s ended", "events");
    wr(`LPI2C_EV_ENABLE, 32'h3E);
    wr(`LPI2C_TIMEOUT, 32'h3C);
    run(1'b0, 3'h0);
    `CHK("timeout moment", 1'b1, n >= 58 && n <= 64)
    `CHK("timeout read strobe", 1'b0, we)
    `CHK("pads after timeout", 4'h0, pad_oe)
    ev_check(32'h1, 32'h1);
    $display("test %s ended", "timeout");
    results();
  end
endmodule
`default_nettype wire
